// File: hdl/memory_bank_conflict_arbiter.sv
/*
  Memory bank conflict arbiter between the CPU data/program buses and on-chip banks.
  Assumes requesters hold a request only while ready is high, and that writes
  never need back-pressure: they are performed a fixed delay after issue.
*/
`timescale 1ns/1ps
`default_nettype none
module memory_bank_conflict_arbiter #(
  parameter logic [bank_arb_pkg::NUM_BANKS-1:0] DUAL_MASK = bank_arb_pkg::DUAL_MASK_RST,
  parameter int                                 WR_DELAY  = bank_arb_pkg::WRITE_DELAY_CYC
) (
  // Clock and reset
  input  wire logic                                        mclk,
  input  wire logic                                        resetn,
  // Read requests: data X, data Y, coefficient, program fetch
  input  wire bank_arb_pkg::rd_req_t [bank_arb_pkg::NUM_RD-1:0] readReq,
  output logic                     [bank_arb_pkg::NUM_RD-1:0] readReady,
  output logic                     [bank_arb_pkg::NUM_RD-1:0] readStall,
  // Commands issued to the banks, one per read slot
  output bank_arb_pkg::rd_cmd_t    [bank_arb_pkg::NUM_RD-1:0] readCmd,
  // Write issue and the write as performed
  input  wire bank_arb_pkg::wr_req_t                           writeReq,
  output bank_arb_pkg::wr_req_t                                writeCmd,
  // Local repeat loop
  input  wire logic                                            loopActive,
  input  wire bank_arb_pkg::addr_t                             loopStart
);
  import bank_arb_pkg::*;

  localparam int WR_BITS = $bits(wr_req_t);
  localparam logic [ADDR_W-1:0] IBUF_SPAN = ADDR_W'(IBUF_WORDS);

  // Pending slots, one per read requester
  rd_req_t [NUM_RD-1:0] pend_reg, pend_next;
  logic    [NUM_RD-1:0] ready_reg, ready_next;
  logic    [NUM_RD-1:0] stall_reg, stall_next;
  rd_cmd_t [NUM_RD-1:0] cmd_reg, cmd_next;
  wr_req_t              wcmd_reg, wcmd_next;
  // Loop buffer tracking
  logic loopSeen_reg, loopSeen_next;
  logic loopFull_reg, loopFull_next;

  wr_req_t              wrDue;
  logic [WR_BITS-1:0]   wrDueBits;
  bank_t                wrBank;
  logic                 wrDual;
  bank_t [NUM_RD-1:0]   rdBank;
  logic  [NUM_RD-1:0]   rdDual;
  logic  [NUM_RD-1:0]   grant;
  logic                 bufHit;

  // Write travels to its perform stage
  write_delay_line #(
    .WIDTH (WR_BITS),
    .DEPTH (WR_DELAY)
  ) u_wr_delay (
    .mclk   (mclk),
    .resetn (resetn),
    .din    (writeReq),
    .dout   (wrDueBits)
  );
  assign wrDue = wr_req_t'(wrDueBits);

  bank_decode #(.DUAL_MASK(DUAL_MASK)) u_wr_dec (
    .addr   (wrDue.addr),
    .bank   (wrBank),
    .isDual (wrDual)
  );

  for (genvar g = 0; g < NUM_RD; g++) begin : g_dec
    bank_decode #(.DUAL_MASK(DUAL_MASK)) u_rd_dec (
      .addr   (pend_reg[g].addr),
      .bank   (rdBank[g]),
      .isDual (rdDual[g])
    );
  end

  // Program fetch inside the buffered loop after its first pass
  assign bufHit = loopActive && loopFull_reg &&
                  ((pend_reg[REQ_P].addr - loopStart) < IBUF_SPAN);

  // Per-cycle bank arbitration in fixed priority order
  always_comb begin
    logic [NUM_BANKS-1:0] busy;
    logic [1:0]           reads [NUM_BANKS];
    busy  = '0;
    grant = '0;
    for (int b = 0; b < NUM_BANKS; b++) begin
      reads[b] = 2'h0;
    end
    // The write is older and is never held back; reads in its bank wait if that bank is single
    if (wrDue.valid && !wrDual) begin
      busy[wrBank] = 1'b1;
    end
    // Dual banks take the write in its own slot, so reads are unaffected
    for (int i = 0; i < NUM_RD; i++) begin
      if (pend_reg[i].valid) begin
        if (i == REQ_P && bufHit) begin
          grant[i] = 1'b1;
        end else if (!rdDual[i]) begin
          // Long words count once: one address, one bank cycle
          if (!busy[rdBank[i]]) begin
            grant[i]          = 1'b1;
            busy[rdBank[i]]   = 1'b1;
          end
        end else if (reads[rdBank[i]] < 2'(DUAL_SLOTS)) begin
          grant[i] = 1'b1;
          if (i != REQ_P) begin
            reads[rdBank[i]] = reads[rdBank[i]] + 2'h1;
          end
        end
        // Fetch found two data reads already in its dual bank: it waits
      end
    end
  end

  // Slot, answer and command registers
  always_comb begin
    pend_next  = pend_reg;
    cmd_next   = '0;
    stall_next = '0;
    for (int i = 0; i < NUM_RD; i++) begin
      if (pend_reg[i].valid) begin
        if (grant[i]) begin
          pend_next[i].valid   = 1'b0;
          cmd_next[i].valid    = !(i == REQ_P && bufHit);
          cmd_next[i].longAcc  = pend_reg[i].longAcc;
          cmd_next[i].addr     = pend_reg[i].addr;
          cmd_next[i].bank     = rdBank[i];
        end else begin
          stall_next[i] = 1'b1;
        end
      end else if (readReq[i].valid) begin
        pend_next[i] = readReq[i];
      end
    end
    for (int i = 0; i < NUM_RD; i++) begin
      ready_next[i] = !pend_next[i].valid;
    end
    // Both 16-bit words of a long write go out under one address
    wcmd_next = wrDue;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pend_reg  <= '0;
      cmd_reg   <= '0;
      stall_reg <= '0;
      ready_reg <= '1;
      wcmd_reg  <= '0;
    end else begin
      pend_reg  <= pend_next;
      cmd_reg   <= cmd_next;
      stall_reg <= stall_next;
      ready_reg <= ready_next;
      wcmd_reg  <= wcmd_next;
    end
  end

  // Loop buffer fills during the first pass only
  always_comb begin
    loopSeen_next = loopSeen_reg;
    loopFull_next = loopFull_reg;
    if (!loopActive) begin
      loopSeen_next = 1'b0;
      loopFull_next = 1'b0;
    end else if (grant[REQ_P] && pend_reg[REQ_P].addr == loopStart) begin
      loopSeen_next = 1'b1;
      loopFull_next = loopSeen_reg;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      loopSeen_reg <= 1'b0;
      loopFull_reg <= 1'b0;
    end else begin
      loopSeen_reg <= loopSeen_next;
      loopFull_reg <= loopFull_next;
    end
  end

  assign readReady = ready_reg;
  assign readStall = stall_reg;
  assign readCmd   = cmd_reg;
  assign writeCmd  = wcmd_reg;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  logic xyShare, wrOnX, xLongAlone;
  assign xyShare = pend_reg[REQ_X].valid && pend_reg[REQ_Y].valid &&
                   rdBank[REQ_X] == rdBank[REQ_Y];
  assign wrOnX   = pend_reg[REQ_X].valid && wrDue.valid && !wrDual && wrBank == rdBank[REQ_X];
  assign xLongAlone = pend_reg[REQ_X].valid && pend_reg[REQ_X].longAcc &&
                      !rdDual[REQ_X] && !wrOnX;

  // Bank uses per cycle; a write counts only in a single bank, a buffered fetch nowhere
  logic [2:0] useCnt [NUM_BANKS];
  always_comb begin
    for (int b = 0; b < NUM_BANKS; b++) begin
      useCnt[b] = 3'h0;
      if (wrDue.valid && !wrDual && wrBank == bank_t'(b)) begin
        useCnt[b] = 3'h1;
      end
      for (int i = 0; i < NUM_RD; i++) begin
        if (grant[i] && !(i == REQ_P && bufHit) && rdBank[i] == bank_t'(b)) begin
          useCnt[b] = useCnt[b] + 3'h1;
        end
      end
    end
  end

  sequence s_write_hits_pair;
    xyShare && !rdDual[REQ_X] && wrOnX;
  endsequence
  sequence s_bank_then_free;
    s_write_hits_pair ##1 !wrOnX;
  endsequence
  sequence s_x_then_y;
    (cmd_reg[REQ_X].valid && stall_reg[REQ_Y]) ##1 1'b1;
  endsequence

  a_dual_pair: assert property (xyShare && rdDual[REQ_X] |->
    ##1 (cmd_reg[REQ_X].valid && cmd_reg[REQ_Y].valid))
    else $error("dual bank did not serve both reads");
  a_single_once: assert property (xyShare && !rdDual[REQ_X] |->
    ##1 !(cmd_reg[REQ_X].valid && cmd_reg[REQ_Y].valid))
    else $error("single bank served two reads in one cycle");
  a_single_busy: assert property (wrOnX |-> ##1 stall_reg[REQ_X])
    else $error("read shared a single bank cycle with a write");
  a_triple_stall: assert property (xyShare && rdDual[REQ_X] &&
    pend_reg[REQ_C].valid && rdBank[REQ_C] == rdBank[REQ_X] |->
    ##1 (stall_reg[REQ_C] && !stall_reg[REQ_X]))
    else $error("triple read in one dual bank not resolved");
  a_coef_apart: assert property (xyShare && rdDual[REQ_X] && pend_reg[REQ_C].valid &&
    rdDual[REQ_C] && rdBank[REQ_C] != rdBank[REQ_X] |->
    ##1 !(stall_reg[REQ_C] || stall_reg[REQ_Y]))
    else $error("coefficient in other bank stalled");
  a_write_first: assert property (s_write_hits_pair |->
    ##1 (stall_reg[REQ_X] && stall_reg[REQ_Y]))
    else $error("write-then-dual-read conflict missed");
  a_reads_follow: assert property (s_bank_then_free |->
    ##1 s_x_then_y)
    else $error("X read not served right after the write");
  a_dual_nowait: assert property (xyShare && rdDual[REQ_X] && wrDue.valid &&
    wrBank == rdBank[REQ_X] |-> ##1 !stall_reg[REQ_X] && !stall_reg[REQ_Y])
    else $error("write in dual bank delayed reads");
  a_fetch_yield: assert property (xyShare && rdDual[REQ_X] && pend_reg[REQ_P].valid &&
    !bufHit && rdBank[REQ_P] == rdBank[REQ_X] |->
    ##1 stall_reg[REQ_P] ##1 !stall_reg[REQ_P])
    else $error("fetch not delayed exactly one cycle");
  a_ibuf_skip: assert property (pend_reg[REQ_P].valid && bufHit |->
    ##1 (!stall_reg[REQ_P] && !cmd_reg[REQ_P].valid))
    else $error("buffered fetch touched a bank");
  a_long_once: assert property (xLongAlone |->
    ##1 (cmd_reg[REQ_X].valid && cmd_reg[REQ_X].longAcc &&
         cmd_reg[REQ_X].addr == $past(pend_reg[REQ_X].addr)))
    else $error("long read not one access in one cycle");
  a_long_write: assert property (wrDue.valid |->
    ##1 (writeCmd.valid && writeCmd.addr == $past(wrDue.addr)))
    else $error("write not performed in its cycle");
  a_write_words: assert property (wrDue.valid |->
    ##1 (writeCmd.longAcc == $past(wrDue.longAcc) && writeCmd.dataHi == $past(wrDue.dataHi) &&
         writeCmd.dataLo == $past(wrDue.dataLo)))
    else $error("write words changed on the way to the bank");
  a_x_first: assert property (pend_reg[REQ_X].valid && !wrOnX |->
    ##1 cmd_reg[REQ_X].valid)
    else $error("highest priority read stalled without a write");
  a_loop_clear: assert property (!loopActive |-> ##1 !loopFull_reg)
    else $error("loop buffer kept after the loop ended");
  a_ibuf_fill: assert property ($rose(loopFull_reg) |-> $past(loopSeen_reg))
    else $error("loop buffer filled before a first pass");

  // A stalled request keeps its slot, so the requester sees back-pressure
  for (genvar g = 0; g < NUM_RD; g++) begin : g_slot_chk
    a_stall_held: assert property (stall_reg[g] |-> !ready_reg[g])
      else $error("stalled slot reported ready");
    a_take_slot: assert property (readReq[g].valid && ready_reg[g] |->
      ##1 !ready_reg[g])
      else $error("offered request not taken into its slot");
  end

  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank_chk
    if (DUAL_MASK[b]) begin : g_dual
      a_dual_limit: assert property (useCnt[b] <= 3'h2)
        else $error("dual bank took more than two reads");
    end else begin : g_single
      a_single_limit: assert property (useCnt[b] <= 3'h1)
        else $error("single bank took two accesses in one cycle");
    end
  end
endmodule
`default_nettype wire

// File: include/bank_arb_pkg.sv
/*
  Shared types and constants for the memory bank conflict arbiter.
  Assumes a 16-bit word-addressed data space split into equal banks.
*/
`default_nettype none
package bank_arb_pkg;
  localparam int ADDR_W     = 16;
  localparam int WORD_W     = 16;
  localparam int BANK_W     = 3;
  localparam int NUM_BANKS  = 8;
  localparam int BANK_SHIFT = 13;
  localparam int NUM_RD     = 4;
  // Requester slots, highest read priority first
  localparam int REQ_X = 0;
  localparam int REQ_Y = 1;
  localparam int REQ_C = 2;
  localparam int REQ_P = 3;
  localparam int DUAL_SLOTS = 2;
  localparam int CLK_PERIOD_PS = 5000;
  // A write is performed this long after it is issued
  localparam int WRITE_DELAY_PS = 10000;
  localparam int WRITE_DELAY_CYC = (WRITE_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int IBUF_BYTES = 64;
  localparam int IBUF_WORDS = IBUF_BYTES / 2;
  localparam logic [NUM_BANKS-1:0] DUAL_MASK_RST = 8'h0F;

  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [WORD_W-1:0] word_t;
  typedef logic [BANK_W-1:0] bank_t;

  typedef struct packed {
    logic  valid;
    logic  longAcc;
    addr_t addr;
  } rd_req_t;

  typedef struct packed {
    logic  valid;
    logic  longAcc;
    addr_t addr;
    bank_t bank;
  } rd_cmd_t;

  typedef struct packed {
    logic  valid;
    logic  longAcc;
    addr_t addr;
    word_t dataHi;
    word_t dataLo;
  } wr_req_t;
endpackage
`default_nettype wire

// File: hdl/bank_decode.sv
/*
  Bank index and bank kind for one access address.
  Assumes banks are contiguous, power-of-two sized.
*/
`timescale 1ns/1ps
`default_nettype none
module bank_decode #(
  parameter logic [bank_arb_pkg::NUM_BANKS-1:0] DUAL_MASK = bank_arb_pkg::DUAL_MASK_RST
) (
  // Access address
  input  wire bank_arb_pkg::addr_t addr,
  // Decoded bank
  output bank_arb_pkg::bank_t      bank,
  output logic                     isDual
);
  import bank_arb_pkg::*;

  assign bank   = addr[BANK_SHIFT +: BANK_W];
  assign isDual = DUAL_MASK[bank];
endmodule
`default_nettype wire

// File: hdl/write_delay_line.sv
/*
  Fixed-latency shift line that carries an issued write to its perform stage.
  Assumes one write issued per cycle at most.
*/
`timescale 1ns/1ps
`default_nettype none
module write_delay_line #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             resetn,
  // Data
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage_reg  [DEPTH];
  logic [WIDTH-1:0] stage_next [DEPTH];

  always_comb begin
    stage_next[0] = din;
    for (int i = 1; i < DEPTH; i++) begin
      stage_next[i] = stage_reg[i-1];
    end
  end

  always_ff @(posedge mclk) begin
    for (int i = 0; i < DEPTH; i++) begin
      if (!resetn) begin
        stage_reg[i] <= '0;
      end else begin
        stage_reg[i] <= stage_next[i];
      end
    end
  end

  assign dout = stage_reg[DEPTH-1];
endmodule
`default_nettype wire

// File: testbench/cpu_bus_model.sv
/*
  CPU-side request driver for the four read slots.
  Assumes the arbiter takes a request at the edge where ready is high.
*/
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
  // Clock and reset
  input  wire logic                                           mclk,
  input  wire logic                                           resetn,
  // Read slots
  input  wire logic                [bank_arb_pkg::NUM_RD-1:0] readReady,
  output var  bank_arb_pkg::rd_req_t [bank_arb_pkg::NUM_RD-1:0] readReq
);
  import bank_arb_pkg::*;
  initial readReq = '0;
  // Idle lines carry the inverse of the last value, never a stale copy
  always @(posedge mclk)
    for (int s = 0; s < NUM_RD; s++)
      if (!resetn || (readReq[s].valid && readReady[s]))
        readReq[s] <= '{1'b0, ~readReq[s].longAcc, ~readReq[s].addr};
  task automatic post(input int s, input addr_t a, input logic l);
    readReq[s] <= '{1'b1, l, a};
  endtask
endmodule
`default_nettype wire

// File: testbench/test_memory_bank_conflict_arbiter.sv
/*
  Self-checking bench for the bank conflict arbiter.
  Assumes default parameters: banks 0-3 dual, write performed 2 cycles on.
*/
`timescale 1ns/1ps
`default_nettype none
module test_memory_bank_conflict_arbiter;
  import bank_arb_pkg::*;
  logic                 mclk, resetn, loopActive;
  addr_t                loopStart;
  wr_req_t              writeReq, writeCmd, wSeen;
  rd_req_t [NUM_RD-1:0] readReq;
  rd_cmd_t [NUM_RD-1:0] readCmd;
  logic [NUM_RD-1:0]    readReady, readStall;
  logic [31:0]          cyc, wCyc, p, n;
  logic [31:0]          gCyc [NUM_RD];
  logic [31:0]          nStall [NUM_RD];
  logic [31:0]          nBusy [NUM_RD];
  rd_cmd_t              seen [NUM_RD];
  int                   fail_count, checked;

  memory_bank_conflict_arbiter i_memory_bank_conflict_arbiter (.mclk, .resetn,
    .readReq, .readReady, .readStall, .readCmd, .writeReq, .writeCmd,
    .loopActive, .loopStart);
  cpu_bus_model i_cpu_bus_model (.mclk, .resetn, .readReady, .readReq);

  initial begin
    mclk = 0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;
  // Sampled mid-cycle so every registered output has settled
  always @(negedge mclk) begin
    for (int s = 0; s < NUM_RD; s++) begin
      if (readCmd[s].valid === 1'b1) begin
        gCyc[s] = cyc;
        seen[s] = readCmd[s];
      end
      if (readStall[s] === 1'b1) nStall[s] = nStall[s] + 1;
      if (readReady[s] === 1'b0) nBusy[s] = nBusy[s] + 1;
    end
    if (writeCmd.valid === 1'b1) begin
      wCyc = cyc;
      wSeen = writeCmd;
    end
  end

  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic finish_test();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic clr();
    for (int s = 0; s < NUM_RD; s++) begin
      gCyc[s] = '1;
      nStall[s] = 0;
      nBusy[s] = 0;
    end
    wCyc = '1;
  endtask
  task automatic rd(input logic [3:0] en, input addr_t a0, a1, a2, a3, input logic lx);
    addr_t a [NUM_RD];
    @(posedge mclk);
    clr();
    p = cyc + 1;
    a = '{a0, a1, a2, a3};
    for (int s = 0; s < NUM_RD; s++)
      if (en[s]) i_cpu_bus_model.post(s, a[s], s == REQ_X && lx);
  endtask
  task automatic settle();
    repeat (10) @(posedge mclk);
  endtask
  // Write issued one edge before a dual read of the same bank
  task automatic wr_rd(input addr_t wa);
    @(posedge mclk);
    n = cyc + 1;
    writeReq <= '{1'b1, 1'b1, wa, 16'hA5C3, 16'h3C5A};
    rd(4'b0011, wa + 16'h0002, wa + 16'h0004, '0, '0, 1'b0);
    writeReq <= '0;
    settle();
    check("writeCmd cycle", wCyc, n + WRITE_DELAY_CYC + 1);
    check("writeCmd addr", wSeen.addr, wa);
    check("writeCmd data", {wSeen.dataHi, wSeen.dataLo}, 32'hA5C33C5A);
  endtask

  task automatic t_dual_pair();
    rd(4'b0011, 16'h0010, 16'h0020, '0, '0, 1'b0);
    settle();
    check("X grant", gCyc[REQ_X], p + 2);
    check("Y grant", gCyc[REQ_Y], p + 2);
    check("Y stalls", nStall[REQ_Y], 0);
  endtask
  task automatic t_single_pair();
    rd(4'b0011, 16'h8000, 16'h8004, '0, '0, 1'b0);
    settle();
    check("X grant", gCyc[REQ_X], p + 2);
    check("Y grant", gCyc[REQ_Y], p + 3);
    check("Y stalls", nStall[REQ_Y], 1);
    check("X busy", nBusy[REQ_X], 1);
    check("Y busy", nBusy[REQ_Y], 2);
  endtask
  task automatic t_triple_same();
    rd(4'b0111, 16'h0010, 16'h0020, 16'h0030, '0, 1'b0);
    settle();
    check("Y grant", gCyc[REQ_Y], p + 2);
    check("C grant", gCyc[REQ_C], p + 3);
    check("C stalls", nStall[REQ_C], 1);
  endtask
  task automatic t_triple_split();
    rd(4'b0111, 16'h2000, 16'h2010, 16'h4000, '0, 1'b0);
    settle();
    check("Y grant", gCyc[REQ_Y], p + 2);
    check("C grant", gCyc[REQ_C], p + 2);
    check("C bank", seen[REQ_C].bank, 2);
  endtask
  task automatic t_write_single();
    wr_rd(16'hA000);
    check("X grant", gCyc[REQ_X], n + 4);
    check("Y grant", gCyc[REQ_Y], n + 5);
    check("X busy", nBusy[REQ_X], 2);
    check("Y busy", nBusy[REQ_Y], 3);
  endtask
  task automatic t_write_dual();
    wr_rd(16'h6000);
    check("X grant", gCyc[REQ_X], n + 3);
    check("Y grant", gCyc[REQ_Y], n + 3);
  endtask
  task automatic t_fetch_clash();
    rd(4'b1011, 16'h0010, 16'h0020, '0, 16'h0040, 1'b0);
    settle();
    check("X grant", gCyc[REQ_X], p + 2);
    check("P grant", gCyc[REQ_P], p + 3);
  endtask
  task automatic t_long_read();
    rd(4'b0001, 16'hC008, '0, '0, '0, 1'b1);
    settle();
    check("X grant", gCyc[REQ_X], p + 2);
    check("X long", seen[REQ_X].longAcc, 1);
    check("X addr", seen[REQ_X].addr, 16'hC008);
    check("X bank", seen[REQ_X].bank, 6);
  endtask
  task automatic t_loop();
    loopActive <= 1'b1;
    loopStart <= 16'h0100;
    repeat (2) begin
      rd(4'b1000, '0, '0, '0, 16'h0100, 1'b0);
      settle();
      check("P fill grant", gCyc[REQ_P], p + 2);
    end
    rd(4'b1011, 16'h0010, 16'h0020, '0, 16'h0100, 1'b0);
    settle();
    check("P refetch", gCyc[REQ_P], 32'hFFFFFFFF);
    check("P stalls", nStall[REQ_P], 0);
    check("P busy", nBusy[REQ_P], 1);
    loopActive <= 1'b0;
  endtask

  initial begin
    cyc = 0;
    resetn = 0;
    loopActive = 0;
    loopStart = '0;
    writeReq = '0;
    fail_count = 0;
    checked = 0;
    clr();
    repeat (10) @(posedge mclk);
    check("ready in reset", readReady, 4'hF);
    check("cmd in reset", 32'(|readCmd), 0);
    check("stall in reset", 32'(|readStall), 0);
    check("writeCmd in reset", 32'(|writeCmd), 0);
    resetn <= 1'b1;
    t_dual_pair();
    t_single_pair();
    t_triple_same();
    t_triple_split();
    t_write_single();
    t_write_dual();
    t_fetch_clash();
    t_long_read();
    t_loop();
    finish_test();
  end
  // Whole sequence needs about 130 cycles
  initial begin
    repeat (2000) @(posedge mclk);
    fail_count++;
    finish_test();
  end
endmodule
`default_nettype wire
